// ### common/ema_pkg.sv
// package of shared constants and types for the extended memory alu block
// assumes a 32-bit avalon-mm slave port with byte addresses and one clock
package ema_pkg;

  // ==========================================================
  // widths and sizes
  localparam int EMA_DW = 8;
  localparam int EMA_MEM_DEPTH = 64;
  localparam int EMA_MAW = 6;
  localparam int EMA_BAW = 10;
  localparam int EMA_OPW = 5;
  localparam int EMA_FW = 6;

  // ==========================================================
  // register byte offsets
  localparam logic [9:0] EMA_OFF_CMD = 10'h000;
  localparam logic [9:0] EMA_OFF_ACC = 10'h004;
  localparam logic [9:0] EMA_OFF_FLAGS = 10'h008;
  localparam logic [9:0] EMA_OFF_STAT = 10'h00c;
  // memory window: one byte per word from this base
  localparam logic [1:0] EMA_MEM_SEL = 2'h1;

  // ==========================================================
  // command and status register field positions
  localparam int EMA_CMD_OP_LSB = 0;
  localparam int EMA_CMD_BIT_LSB = 8;
  localparam int EMA_CMD_ADR_LSB = 16;
  localparam int EMA_STAT_BUSY = 0;
  localparam int EMA_STAT_SKIP = 1;
  localparam int EMA_STAT_DUMMY = 2;

  // ==========================================================
  // flag bit positions
  localparam int EMA_F_C = 0;
  localparam int EMA_F_AC = 1;
  localparam int EMA_F_Z = 2;
  localparam int EMA_F_OV = 3;
  localparam int EMA_F_SC = 4;
  localparam int EMA_F_CZ = 5;

  // ==========================================================
  // constants and reset values
  localparam logic [7:0] EMA_FULL_BYTE = 8'hff;
  localparam logic [7:0] EMA_ONE = 8'h01;
  localparam logic [7:0] EMA_ACC_RST = 8'h00;
  localparam logic [5:0] EMA_FLAGS_RST = 6'h00;
  // dummy cycles after a taken skip: three cycles in all
  localparam logic [1:0] EMA_SKIP_DUMMIES = 2'h2;

  // ==========================================================
  // operations, numbered in this order from zero
  typedef enum logic [4:0] {
    OP_NOP,
    OP_EXT_MOVE_LOAD,
    OP_EXT_MOVE_STORE,
    OP_EXT_BITWISE_OR_TO_WORK,
    OP_EXT_BITWISE_OR_TO_MEM,
    OP_EXT_ROTATE_LEFT_MEM,
    OP_EXT_ROTATE_LEFT_TO_WORK,
    OP_EXT_ROTATE_LEFT_CARRY_MEM,
    OP_EXT_ROTATE_LEFT_CARRY_WORK,
    OP_EXT_ROTATE_RIGHT_MEM,
    OP_EXT_ROTATE_RIGHT_TO_WORK,
    OP_EXT_ROTATE_RIGHT_CARRY_MEM,
    OP_EXT_ROTATE_RIGHT_CARRY_WORK,
    OP_EXT_SUBTRACT_BORROW_TO_WORK,
    OP_EXT_SUBTRACT_BORROW_TO_MEM,
    OP_EXT_SUBTRACT_TO_WORK,
    OP_EXT_SUBTRACT_TO_MEM,
    OP_EXT_DECREMENT_SKIP_ZERO,
    OP_EXT_DECREMENT_SKIP_ZERO_WORK,
    OP_EXT_INCREMENT_SKIP_ZERO,
    OP_EXT_INCREMENT_SKIP_ZERO_WORK,
    OP_EXT_SET_BITS,
    OP_EXT_SET_ONE_BIT,
    OP_EXT_SKIP_BIT_NONZERO,
    OP_EXT_SKIP_NONZERO
  } ema_op_e;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_DUMMY
  } ema_state_e;

endpackage : ema_pkg

// ### logic/ema_sub.sv
// subtract unit: difference and all six arithmetic flags
// assumes operands and flags come from registers of the caller
module ema_sub (
  // operands
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  // borrow chain control
  input wire logic use_carry,
  input wire logic carry_in,
  input wire logic cz_in,
  // results
  output logic [7:0] diff,
  output logic [5:0] flags
);
  import ema_pkg::*;

  // ==========================================================
  // arithmetic
  logic borrow;
  logic [8:0] full;
  logic [4:0] low;

  // borrow in is the inverted carry, only for the chained form
  assign borrow = use_carry & ~carry_in;

  // one extra bit catches the borrow out
  always_comb begin
    full = {1'b0, acc} - {1'b0, mem} - {8'h00, borrow};
    low = {1'b0, acc[3:0]} - {1'b0, mem[3:0]} - {4'h0, borrow};
    diff = full[7:0];
    flags = '0;
    flags[EMA_F_C] = ~full[8];
    flags[EMA_F_AC] = ~low[4];
    flags[EMA_F_OV] = (acc[7] ^ mem[7]) & (acc[7] ^ full[7]);
    flags[EMA_F_SC] = flags[EMA_F_OV] ^ full[7];
    flags[EMA_F_Z] = (full[7:0] == 8'h00);
    // chained form keeps zero across bytes
    flags[EMA_F_CZ] = use_carry ? (flags[EMA_F_Z] & cz_in) : flags[EMA_F_Z];
  end

endmodule : ema_sub

// ### logic/ema_top.sv
// extended memory alu: accumulator, flags, data memory and sequencer
// assumes an avalon-mm master that holds each request until waitrequest is low
// What this block does
// - load accumulator from memory, flags kept
// - store accumulator to memory, flags kept
// - or into accumulator or memory, zero only
// - rotate left, bit 7 to bit 0
// - rotate left through carry, carry only
// - rotate right, bit 0 to bit 7
// - rotate right through carry, carry only
// - rotate into accumulator leaves memory alone
// - subtract with inverted carry as borrow
// - plain subtract, accumulator or memory destination
// - carry clear when negative, else set
// - subtract updates all six arithmetic flags
// - decrement memory, skip when zero
// - increment memory, skip when zero
// - accumulator variants leave memory unchanged
// - taken skip takes three cycles
// - whole byte set writes all ones
// - bit set forces one bit only
// - skip when selected bit is set
// - byte test rewrites byte, skips nonzero
//
// The Avalon-MM interface to the registers and the address map were decided locally.
module ema_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // avalon-mm slave
  input wire logic [ema_pkg::EMA_BAW-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // sequencer view
  output logic SKIP_TAKEN,
  output logic DUMMY_SLOT
);
  import ema_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    ema_state_e state; // sequencer
    ema_op_e op; // latched operation
    logic [2:0] bit_idx; // selected bit
    logic [EMA_MAW-1:0] adr; // data memory address
    logic [7:0] acc; // accumulator
    logic [EMA_FW-1:0] flags; // status flags
    logic [EMA_MEM_DEPTH-1:0][7:0] mem; // data memory
    logic [1:0] dummies; // dummy cycles left
    logic skip; // last instruction skipped
    logic resp; // bus answer cycle
    logic [31:0] rdata; // latched read data
  } ema_st_s;

  ema_st_s r_reg;
  ema_st_s r_next;

  // subtract unit wires
  logic [7:0] sub_diff;
  logic [5:0] sub_flags;
  logic sub_chain;
  logic [7:0] m_byte;

  // ==========================================================
  // helpers
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  function automatic logic [7:0] bit_mask(input logic [2:0] i);
    bit_mask = EMA_ONE << i;
  endfunction : bit_mask

  // byte-lane merge of a 32-bit word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        res[k*8 +: 8] = nw[k*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  // memory window decode
  function automatic logic mem_hit(input logic [EMA_BAW-1:0] a);
    mem_hit = (a[EMA_BAW-1:EMA_BAW-2] == EMA_MEM_SEL) && (a[1:0] == 2'h0);
  endfunction : mem_hit

  // command register image
  function automatic logic [31:0] cmd_word(input ema_st_s s);
    logic [31:0] w;
    w = '0;
    w[EMA_CMD_OP_LSB +: EMA_OPW] = s.op;
    w[EMA_CMD_BIT_LSB +: 3] = s.bit_idx;
    w[EMA_CMD_ADR_LSB +: EMA_MAW] = s.adr;
    cmd_word = w;
  endfunction : cmd_word

  // register read mux; unmapped reads as zero
  function automatic logic [31:0] reg_read(input ema_st_s s, input logic [EMA_BAW-1:0] a);
    logic [31:0] w;
    w = '0;
    if (mem_hit(a)) begin
      w[7:0] = s.mem[a[EMA_MAW+1:2]];
    end else begin
      case (a)
        EMA_OFF_CMD: w = cmd_word(s);
        EMA_OFF_ACC: w[7:0] = s.acc;
        EMA_OFF_FLAGS: w[EMA_FW-1:0] = s.flags;
        EMA_OFF_STAT: begin
          w[EMA_STAT_BUSY] = (s.state != ST_IDLE);
          w[EMA_STAT_SKIP] = s.skip;
          w[EMA_STAT_DUMMY] = (s.state == ST_DUMMY);
        end
        default: w = '0;
      endcase
    end
    reg_read = w;
  endfunction : reg_read

  // ==========================================================
  // subtract datapath
  assign m_byte = r_reg.mem[r_reg.adr];
  // chained borrow only for the borrow forms
  assign sub_chain = (r_reg.op == OP_EXT_SUBTRACT_BORROW_TO_WORK) ||
                     (r_reg.op == OP_EXT_SUBTRACT_BORROW_TO_MEM);

  ema_sub i_ema_sub (
    .acc(r_reg.acc),
    .mem(m_byte),
    .use_carry(sub_chain),
    .carry_in(r_reg.flags[EMA_F_C]),
    .cz_in(r_reg.flags[EMA_F_CZ]),
    .diff(sub_diff),
    .flags(sub_flags)
  );

  // ==========================================================
  // next state
  // execution happens in one cycle; the bus is stalled while busy,
  // which keeps software from racing the accumulator or memory
  always_comb begin
    logic [31:0] cw;
    logic [7:0] res;
    logic to_acc;
    logic to_mem;
    logic skip;
    r_next = r_reg;
    r_next.resp = 1'b0;
    cw = '0;
    res = 8'h00;
    to_acc = 1'b0;
    to_mem = 1'b0;
    skip = 1'b0;

    // bus: first cycle latches read data, second answers
    if ((READ || WRITE) && !r_reg.resp && r_reg.state == ST_IDLE) begin
      r_next.resp = 1'b1;
      r_next.rdata = reg_read(r_reg, ADDRESS);
    end

    // write takes effect at the answer edge
    if (WRITE && r_reg.resp) begin
      if (mem_hit(ADDRESS)) begin
        if (BYTEENABLE[0]) begin
          r_next.mem[ADDRESS[EMA_MAW+1:2]] = WRITEDATA[7:0];
        end
      end else begin
        case (ADDRESS)
          EMA_OFF_CMD: begin
            // a command write starts execution
            cw = merge(cmd_word(r_reg), WRITEDATA, BYTEENABLE);
            r_next.op = ema_op_e'(cw[EMA_CMD_OP_LSB +: EMA_OPW]);
            r_next.bit_idx = cw[EMA_CMD_BIT_LSB +: 3];
            r_next.adr = cw[EMA_CMD_ADR_LSB +: EMA_MAW];
            r_next.state = ST_EXEC;
            r_next.skip = 1'b0;
          end
          EMA_OFF_ACC: begin
            if (BYTEENABLE[0]) begin
              r_next.acc = WRITEDATA[7:0];
            end
          end
          EMA_OFF_FLAGS: begin
            if (BYTEENABLE[0]) begin
              r_next.flags = WRITEDATA[EMA_FW-1:0];
            end
          end
          // status and unmapped: write ignored
          default: r_next.state = r_reg.state;
        endcase
      end
    end

    // sequencer
    case (r_reg.state)
      ST_IDLE: begin
        r_next.dummies = r_reg.dummies;
      end
      ST_EXEC: begin
        case (r_reg.op)
          OP_EXT_MOVE_LOAD: begin
            res = m_byte;
            to_acc = 1'b1;
          end
          OP_EXT_MOVE_STORE: begin
            res = r_reg.acc;
            to_mem = 1'b1;
          end
          OP_EXT_BITWISE_OR_TO_WORK, OP_EXT_BITWISE_OR_TO_MEM: begin
            res = r_reg.acc | m_byte;
            to_acc = (r_reg.op == OP_EXT_BITWISE_OR_TO_WORK);
            to_mem = !to_acc;
            r_next.flags[EMA_F_Z] = is_zero(res);
          end
          OP_EXT_ROTATE_LEFT_MEM, OP_EXT_ROTATE_LEFT_TO_WORK: begin
            res = {m_byte[6:0], m_byte[7]};
            to_acc = (r_reg.op == OP_EXT_ROTATE_LEFT_TO_WORK);
            to_mem = !to_acc;
          end
          OP_EXT_ROTATE_LEFT_CARRY_MEM, OP_EXT_ROTATE_LEFT_CARRY_WORK: begin
            res = {m_byte[6:0], r_reg.flags[EMA_F_C]};
            r_next.flags[EMA_F_C] = m_byte[7];
            to_acc = (r_reg.op == OP_EXT_ROTATE_LEFT_CARRY_WORK);
            to_mem = !to_acc;
          end
          OP_EXT_ROTATE_RIGHT_MEM, OP_EXT_ROTATE_RIGHT_TO_WORK: begin
            res = {m_byte[0], m_byte[7:1]};
            to_acc = (r_reg.op == OP_EXT_ROTATE_RIGHT_TO_WORK);
            to_mem = !to_acc;
          end
          OP_EXT_ROTATE_RIGHT_CARRY_MEM, OP_EXT_ROTATE_RIGHT_CARRY_WORK: begin
            res = {r_reg.flags[EMA_F_C], m_byte[7:1]};
            r_next.flags[EMA_F_C] = m_byte[0];
            to_acc = (r_reg.op == OP_EXT_ROTATE_RIGHT_CARRY_WORK);
            to_mem = !to_acc;
          end
          OP_EXT_SUBTRACT_BORROW_TO_WORK, OP_EXT_SUBTRACT_BORROW_TO_MEM: begin
            res = sub_diff;
            r_next.flags = sub_flags;
            to_acc = (r_reg.op == OP_EXT_SUBTRACT_BORROW_TO_WORK);
            to_mem = !to_acc;
          end
          OP_EXT_SUBTRACT_TO_WORK, OP_EXT_SUBTRACT_TO_MEM: begin
            res = sub_diff;
            r_next.flags = sub_flags;
            to_acc = (r_reg.op == OP_EXT_SUBTRACT_TO_WORK);
            to_mem = !to_acc;
          end
          OP_EXT_DECREMENT_SKIP_ZERO: begin
            res = m_byte - EMA_ONE;
            to_mem = 1'b1;
            skip = is_zero(res);
          end
          OP_EXT_INCREMENT_SKIP_ZERO: begin
            res = m_byte + EMA_ONE;
            to_mem = 1'b1;
            skip = is_zero(res);
          end
          OP_EXT_DECREMENT_SKIP_ZERO_WORK, OP_EXT_INCREMENT_SKIP_ZERO_WORK: begin
            res = (r_reg.op == OP_EXT_DECREMENT_SKIP_ZERO_WORK) ?
                  (m_byte - EMA_ONE) : (m_byte + EMA_ONE);
            to_acc = 1'b1;
            skip = is_zero(res);
          end
          OP_EXT_SET_BITS: begin
            res = EMA_FULL_BYTE;
            to_mem = 1'b1;
          end
          OP_EXT_SET_ONE_BIT: begin
            res = m_byte | bit_mask(r_reg.bit_idx);
            to_mem = 1'b1;
          end
          OP_EXT_SKIP_BIT_NONZERO: begin
            skip = m_byte[r_reg.bit_idx];
          end
          OP_EXT_SKIP_NONZERO: begin
            res = m_byte;
            to_mem = 1'b1;
            skip = !is_zero(m_byte);
          end
          // no operation or unknown code
          default: res = 8'h00;
        endcase
        if (to_acc) begin
          r_next.acc = res;
        end
        if (to_mem) begin
          r_next.mem[r_reg.adr] = res;
        end
        r_next.skip = skip;
        // dummy slots on a taken skip
        if (skip) begin
          r_next.state = ST_DUMMY;
          r_next.dummies = EMA_SKIP_DUMMIES - 2'h1;
        end else begin
          r_next.state = ST_IDLE;
        end
      end
      ST_DUMMY: begin
        if (r_reg.dummies == 2'h0) begin
          r_next.state = ST_IDLE;
        end else begin
          r_next.dummies = r_reg.dummies - 2'h1;
        end
      end
      default: r_next.state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // state register; memory also clears so reads are defined
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      r_reg <= '{state: ST_IDLE, op: OP_NOP, bit_idx: 3'h0, adr: '0,
                 acc: EMA_ACC_RST, flags: EMA_FLAGS_RST, mem: '0,
                 dummies: 2'h0, skip: 1'b0, resp: 1'b0, rdata: 32'h0000_0000};
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // outputs
  // waitrequest holds while busy and in the latch cycle
  assign WAITREQUEST = (READ || WRITE) && !r_reg.resp;
  assign READDATA = r_reg.rdata;
  assign SKIP_TAKEN = r_reg.skip;
  assign DUMMY_SLOT = (r_reg.state == ST_DUMMY);

endmodule : ema_top

// ### verification/ema_chk.sv
// concurrent checks on the bus handshake and skip sequencer of ema_top
// assumes it is bound to ema_top and sees only that module's ports
module ema_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // bus request side
  input wire logic [ema_pkg::EMA_BAW-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  // bus answer side
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  // sequencer view
  input wire logic SKIP_TAKEN,
  input wire logic DUMMY_SLOT
);
  // ==========================================================
  // helpers
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic req; // any request pending
  logic cmd_done; // command write accepted this cycle
  assign req = READ | WRITE;
  assign cmd_done = WRITE & !WAITREQUEST & (ADDRESS == ema_pkg::EMA_OFF_CMD);

  // ==========================================================
  // handshake: one answer cycle, bounded wait, read data held
  ans_one_cycle_a: assert property (req && !WAITREQUEST ##1 req |-> WAITREQUEST)
    else $error("answer lasted more than one cycle");
  ans_bound_a: assert property ($rose(req) |-> ##[1:6] !WAITREQUEST)
    else $error("request not answered in time");
  rdata_hold_a: assert property (!req |=> $stable(READDATA))
    else $error("read data moved without a request");
  // taken skip is exec plus two dummies
  dummy_pair_a: assert property ($rose(DUMMY_SLOT) |-> DUMMY_SLOT[*2] ##1 !DUMMY_SLOT)
    else $error("dummy slot length wrong");
  dummy_skip_a: assert property (DUMMY_SLOT |-> SKIP_TAKEN)
    else $error("dummy slot without skip");
  dummy_stall_a: assert property (DUMMY_SLOT && req |-> WAITREQUEST)
    else $error("bus answered during dummy slot");
  cmd_dummy_a: assert property (cmd_done |-> ##2 (SKIP_TAKEN == DUMMY_SLOT) ##2 !DUMMY_SLOT)
    else $error("skip sequence timing wrong");
  // skip outcome belongs to the latest command
  cmd_clear_a: assert property (cmd_done |=> !SKIP_TAKEN)
    else $error("skip flag not cleared by command");
  skip_origin_a: assert property ($rose(SKIP_TAKEN) |-> $past(cmd_done, 2))
    else $error("skip flag rose without command");
  // main scenarios
  cover property (cmd_done ##2 SKIP_TAKEN);
  cover property (DUMMY_SLOT && req);
  cover property (cmd_done ##2 !SKIP_TAKEN);
  cover property (READ && !WAITREQUEST);
endmodule : ema_chk

bind ema_top ema_chk i_ema_chk (.CLK(CLK), .RESETN(RESETN), .ADDRESS(ADDRESS), .READ(READ),
  .WRITE(WRITE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .SKIP_TAKEN(SKIP_TAKEN),
  .DUMMY_SLOT(DUMMY_SLOT));

// ### verification/tb_extended_mem_alu_ops.sv
// self-checking bench for ema_top driven over its avalon-mm port
// assumes the register map and op codes of ema_pkg; one 25 MHz clock
module tb_extended_mem_alu_ops;
  timeunit 1ns;
  timeprecision 1ns;
  import ema_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [EMA_BAW-1:0] ADDRESS = '0;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [31:0] WRITEDATA = '0;
  logic [3:0] BYTEENABLE = 4'hf; // lane 0 needed by byte registers
  logic [31:0] READDATA;
  logic WAITREQUEST;
  logic SKIP_TAKEN;
  logic DUMMY_SLOT;
  int n_errors = 0;
  int samples_checked = 0;

  always #20 CLK = ~CLK;

  ema_top i_ema_top (.CLK(CLK), .RESETN(RESETN), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .SKIP_TAKEN(SKIP_TAKEN), .DUMMY_SLOT(DUMMY_SLOT));

  // ==========================================================
  // common tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one avalon transfer: request held until waitrequest is seen low at a rising edge;
  // values read at the edge are those before it, as the design updates by nonblocking
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int t;
    @(posedge CLK);
    ADDRESS <= a;
    WRITEDATA <= d;
    WRITE <= wr;
    READ <= !wr;
    t = 0;
    do begin
      @(posedge CLK);
      t++;
    end while (WAITREQUEST !== 1'b0 && t < 20);
    check("answer within wait limit", 32'h1, {31'h0, t < 20});
    // read data taken at the answer edge, release only after it
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string what, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, exp, q);
  endtask : rd

  function automatic logic [9:0] mem_adr(input logic [5:0] i);
    return 10'h100 + {2'h0, i, 2'h0};
  endfunction : mem_adr

  // reference behaviour of one instruction
  task automatic model(input logic [4:0] op, input logic [2:0] b, input logic [7:0] m0,
                       inout logic [7:0] a, inout logic [5:0] f,
                       output logic [7:0] m, output logic sk);
    logic [8:0] d;
    logic [4:0] n;
    logic bi;
    logic ov;
    m = m0;
    sk = 1'b0;
    bi = 1'b0;
    case (op)
      5'h01: a = m0;
      5'h02: m = a;
      5'h03, 5'h04: begin
        d[7:0] = a | m0;
        f[EMA_F_Z] = d[7:0] == 8'h00;
        if (op == 5'h03) a = d[7:0];
        else m = d[7:0];
      end
      5'h05: m = {m0[6:0], m0[7]};
      5'h06: a = {m0[6:0], m0[7]};
      5'h09: m = {m0[0], m0[7:1]};
      5'h0a: a = {m0[0], m0[7:1]};
      5'h07, 5'h08: begin
        d[7:0] = {m0[6:0], f[EMA_F_C]};
        f[EMA_F_C] = m0[7];
        if (op == 5'h07) m = d[7:0];
        else a = d[7:0];
      end
      5'h0b, 5'h0c: begin
        d[7:0] = {f[EMA_F_C], m0[7:1]};
        f[EMA_F_C] = m0[0];
        if (op == 5'h0b) m = d[7:0];
        else a = d[7:0];
      end
      5'h0d, 5'h0e, 5'h0f, 5'h10: begin
        bi = (op < 5'h0f) & ~f[EMA_F_C];
        d = {1'b0, a} - {1'b0, m0} - {8'h00, bi};
        n = {1'b0, a[3:0]} - {1'b0, m0[3:0]} - {4'h0, bi};
        ov = (a[7] ^ m0[7]) & (d[7] ^ a[7]);
        f[EMA_F_CZ] = (d[7:0] == 8'h00) & ((op < 5'h0f) ? f[EMA_F_CZ] : 1'b1);
        f[EMA_F_C] = ~d[8];
        f[EMA_F_AC] = ~n[4];
        f[EMA_F_Z] = d[7:0] == 8'h00;
        f[EMA_F_OV] = ov;
        f[EMA_F_SC] = ov ^ d[7];
        if (op[0]) a = d[7:0];
        else m = d[7:0];
      end
      5'h11: m = m0 - 8'h01;
      5'h12: a = m0 - 8'h01;
      5'h13: m = m0 + 8'h01;
      5'h14: a = m0 + 8'h01;
      5'h15: m = EMA_FULL_BYTE;
      5'h16: m[b] = 1'b1;
      5'h17: sk = m0[b];
      5'h18: sk = m0 != 8'h00;
      default: ;
    endcase
    if (op == 5'h11 || op == 5'h13) sk = m == 8'h00;
    if (op == 5'h12 || op == 5'h14) sk = a == 8'h00;
  endtask : model

  // row: op, bit, address, accumulator, memory byte, flags (one byte each)
  task automatic run(input logic [47:0] r);
    logic [7:0] a;
    logic [7:0] m;
    logic [5:0] f;
    logic sk;
    logic [31:0] nd;
    a = r[23:16];
    f = r[5:0];
    wr(EMA_OFF_ACC, {24'h0, a});
    wr(EMA_OFF_FLAGS, {26'h0, f});
    wr(mem_adr(r[29:24]), {24'h0, r[15:8]});
    wr(EMA_OFF_CMD, {10'h0, r[29:24], 5'h0, r[34:32], 3'h0, r[44:40]});
    nd = 32'h0;
    repeat (4) begin
      @(negedge CLK);
      nd = nd + {31'h0, DUMMY_SLOT};
    end
    model(r[44:40], r[34:32], r[15:8], a, f, m, sk);
    check("dummy slots", sk ? 32'h2 : 32'h0, nd);
    check("skip flag", {31'h0, sk}, {31'h0, SKIP_TAKEN});
    rd("accumulator", EMA_OFF_ACC, {24'h0, a});
    rd("flags", EMA_OFF_FLAGS, {26'h0, f});
    rd("memory byte", mem_adr(r[29:24]), {24'h0, m});
  endtask : run

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd("acc reset", EMA_OFF_ACC, 32'h0);
    rd("flags reset", EMA_OFF_FLAGS, 32'h0);
    rd("status reset", EMA_OFF_STAT, 32'h0);
    rd("memory reset", mem_adr(6'h3f), 32'h0);
  endtask : t_reset

  task automatic t_move_or;
    run(48'h01_00_05_00_5a_3f);
    run(48'h02_00_06_c3_00_00);
    run(48'h03_00_07_00_00_00);
    run(48'h04_00_08_12_40_04);
  endtask : t_move_or

  task automatic t_rotate;
    run(48'h05_00_09_00_81_3e);
    run(48'h06_00_0a_00_80_00);
    run(48'h07_00_0b_00_80_00);
    run(48'h08_00_0c_00_01_01);
    run(48'h09_00_0d_00_01_3f);
    run(48'h0a_00_0e_00_02_00);
    run(48'h0b_00_0f_00_01_00);
    run(48'h0c_00_10_00_00_01);
  endtask : t_rotate

  task automatic t_subtract;
    run(48'h0d_00_11_10_10_00);
    run(48'h0d_00_12_05_05_01);
    run(48'h0e_00_13_80_01_21);
    run(48'h0f_00_14_05_05_00);
    run(48'h10_00_15_00_01_3f);
  endtask : t_subtract

  task automatic t_skip;
    run(48'h11_00_16_00_00_2a);
    run(48'h12_00_17_00_01_2a);
    run(48'h13_00_18_00_05_2a);
    run(48'h14_00_19_00_0f_2a);
    run(48'h17_03_1a_00_f7_2a);
    run(48'h18_00_1b_00_00_2a);
    run(48'h13_00_1c_00_ff_2a);
    run(48'h14_00_1d_00_ff_2a);
    run(48'h17_03_1e_00_08_2a);
    run(48'h18_00_1f_00_01_2a);
    run(48'h11_00_20_00_01_2a);
    rd("status after skip", EMA_OFF_STAT, 32'h2);
  endtask : t_skip

  // read raised during the dummy slots waits for idle
  task automatic t_stall;
    wr(mem_adr(6'h26), 32'h0000_0001);
    wr(EMA_OFF_CMD, 32'h0026_0011);
    rd("status after stalled read", EMA_OFF_STAT, 32'h2);
    rd("stalled decrement result", mem_adr(6'h26), 32'h0);
  endtask : t_stall

  task automatic t_set;
    run(48'h15_00_21_00_00_3f);
    run(48'h16_07_22_00_00_15);
    run(48'h16_00_23_00_fe_2a);
    run(48'h00_00_24_77_33_3f);
    run(48'h1f_00_25_77_33_15);
  endtask : t_set

  task automatic t_bus;
    rd("unmapped read", 10'h200, 32'h0);
    wr(EMA_OFF_ACC, 32'h55);
    BYTEENABLE <= 4'he;
    wr(EMA_OFF_ACC, 32'haa);
    BYTEENABLE <= 4'hf;
    rd("acc without lane 0", EMA_OFF_ACC, 32'h55);
    wr(EMA_OFF_STAT, 32'h7);
    rd("status read only", EMA_OFF_STAT, 32'h0);
  endtask : t_bus

  // ==========================================================
  // verdict and run control
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // watchdog: the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    t_reset();
    t_move_or();
    t_rotate();
    t_subtract();
    t_skip();
    t_stall();
    t_set();
    t_bus();
    final_report();
  end
endmodule : tb_extended_mem_alu_ops
